//--- iq_corr_pkg.sv
package iq_corr_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   // Printed offsets are not all multiples of four, so each is an index
   // and the byte address is four times the index.
   localparam logic [7:0]  IDX_RSVD_0B       = 8'h0b;
   localparam logic [7:0]  IDX_I_GAIN        = 8'h0c;
   localparam logic [7:0]  IDX_CMIX_Q_GAIN   = 8'h0d;
   localparam logic [7:0]  IDX_RSVD_0E       = 8'h0e;
   localparam logic [7:0]  IDX_OUT_LATENCY   = 8'h0f;
   localparam logic [7:0]  IDX_PHASE         = 8'h10;
   localparam logic [7:0]  IDX_SYNC_CFG      = 8'h30;

   localparam logic [15:0] RST_RSVD_0B       = 16'h0000;
   localparam logic [15:0] RST_I_GAIN        = 16'h0400;
   localparam logic [15:0] RST_CMIX_Q_GAIN   = 16'h0400;
   localparam logic [15:0] RST_RSVD_0E       = 16'h0400;
   localparam logic [15:0] RST_OUT_LATENCY   = 16'h0400;
   localparam logic [15:0] RST_PHASE         = 16'h0000;
   localparam logic [15:0] RST_SYNC_CFG      = 16'h0000;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int GAIN_MSB      = 10;
   localparam int GAIN_FRAC     = 10;
   localparam int CMIX_MSB      = 15;
   localparam int CMIX_LSB      = 12;
   localparam int LAT_MSB       = 15;
   localparam int LAT_LSB       = 14;
   localparam int PHASE_MSB     = 11;
   localparam int PHASE_FRAC    = 12;
   localparam int AUTOSYNC_BIT  = 0;

   // ************************************************************
   // AXI responses and sample carrier
   // ************************************************************
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [15:0] i_smp;
      logic [15:0] q_smp;
   } iq_sample_t;

endpackage : iq_corr_pkg

//--- sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // Fill side
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   // Drain side
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]      cnt_q, cnt_d;
   logic             push, pop;

   always_comb
   begin
      push = in_valid && (cnt_q != AW'(0) + (AW+1)'(DEPTH));
      pop  = out_ready && (cnt_q != '0);
      wr_d = push ? ((wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1) : wr_q;
      rd_d = pop ? ((rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage carries no reset so it maps onto plain RAM.
   always_ff @(posedge sys_clk)
   begin
      if (push)
         mem_q[wr_q] <= in_data;
   end

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];

endmodule : sample_fifo

//--- iq_gain_phase_coarse_mixer.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Operation
// - I samples are scaled by an unsigned 11-bit gain with 10 fraction bits.
// - Q samples are scaled by their own unsigned gain in the same format.
// - Control bits 15 to 12 select shifts of +Fs/8, +Fs/4, Fs/2 and -Fs/4.
// - Several selected shifts cascade into a total of n times Fs/8.
// - Bits 15:14 of the latency register delay both outputs 0 to 3 cycles.
// - Phase is 12-bit two's complement covering -0.5 to just under 0.5.
// - The Q sample times the phase value is added into the I sample.
// - With auto-sync enabled, a phase register write raises a sync event.
// - The sync event loads both gains and the phase into use together.
// - Gain register writes alone change only the shadow copies.
// - Both gain fields reset to unity, 0x0400.
module iq_gain_phase_coarse_mixer
   import iq_corr_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   // Clock and reset
   input  wire logic                     sys_clk,
   input  wire logic                     rst,
   // AXI4-Lite write address and data
   input  wire logic [9:0]               s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   // AXI4-Lite read
   input  wire logic [9:0]               s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   // Upstream samples
   input  wire iq_corr_pkg::iq_sample_t  in_sample,
   input  wire logic                     in_valid,
   output logic                          in_ready,
   // Converter samples
   output iq_corr_pkg::iq_sample_t       out_sample,
   output logic                          out_valid
);
   import iq_corr_pkg::*;

   // ************************************************************
   // Register slave
   // ************************************************************
   logic [15:0] i_gain_q, i_gain_d, cmix_q, cmix_d, lat_q, lat_d;
   logic [15:0] phase_q, phase_d, sync_q, sync_d;
   logic [15:0] rsvd0b_q, rsvd0b_d, rsvd0e_q, rsvd0e_d;
   logic        aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
   logic [9:0]  aw_addr_q, aw_addr_d;
   logic [31:0] w_data_q, w_data_d;
   logic [3:0]  w_strb_q, w_strb_d;
   logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic        sync_evt;
   logic        do_wr;
   logic [7:0]  wr_idx;

   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] val,
                                         input logic [3:0]  strb);
      merge = old;
      if (strb[0])
         merge[7:0] = val[7:0];
      if (strb[1])
         merge[15:8] = val[15:8];
   endfunction : merge

   function automatic logic mapped(input logic [7:0] idx);
      mapped = (idx >= IDX_RSVD_0B && idx <= IDX_PHASE) ||
               (idx == IDX_SYNC_CFG);
   endfunction : mapped

   always_comb
   begin
      aw_hold_d = aw_hold_q;
      w_hold_d  = w_hold_q;
      aw_addr_d = aw_addr_q;
      w_data_d  = w_data_q;
      w_strb_d  = w_strb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rresp_d   = rresp_q;
      rdata_d   = rdata_q;
      i_gain_d  = i_gain_q;
      cmix_d    = cmix_q;
      lat_d     = lat_q;
      phase_d   = phase_q;
      sync_d    = sync_q;
      rsvd0b_d  = rsvd0b_q;
      rsvd0e_d  = rsvd0e_q;
      sync_evt  = 1'b0;
      if (s_axi_awvalid && !aw_hold_q)
      begin
         aw_hold_d = 1'b1;
         aw_addr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_q)
      begin
         w_hold_d = 1'b1;
         w_data_d = s_axi_wdata;
         w_strb_d = s_axi_wstrb;
      end
      do_wr  = aw_hold_q && w_hold_q && !bvalid_q;
      wr_idx = aw_addr_q[9:2];
      if (do_wr)
      begin
         aw_hold_d = 1'b0;
         w_hold_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
         unique case (wr_idx)
            IDX_RSVD_0B:     rsvd0b_d = merge(rsvd0b_q, w_data_q, w_strb_q);
            IDX_I_GAIN:      i_gain_d = merge(i_gain_q, w_data_q, w_strb_q);
            IDX_CMIX_Q_GAIN: cmix_d = merge(cmix_q, w_data_q, w_strb_q);
            IDX_RSVD_0E:     rsvd0e_d = merge(rsvd0e_q, w_data_q, w_strb_q);
            IDX_OUT_LATENCY: lat_d = merge(lat_q, w_data_q, w_strb_q);
            IDX_PHASE:
            begin
               phase_d  = merge(phase_q, w_data_q, w_strb_q);
               sync_evt = sync_q[AUTOSYNC_BIT];
            end
            IDX_SYNC_CFG:    sync_d = merge(sync_q, w_data_q, w_strb_q);
            default:         ;
         endcase
      end
      if (bvalid_q && s_axi_bready)
         bvalid_d = 1'b0;
      if (rvalid_q && s_axi_rready)
         rvalid_d = 1'b0;
      if (s_axi_arvalid && !rvalid_q)
      begin
         rvalid_d = 1'b1;
         rresp_d  = mapped(s_axi_araddr[9:2]) ? RESP_OKAY : RESP_SLVERR;
         unique case (s_axi_araddr[9:2])
            IDX_RSVD_0B:     rdata_d = {16'h0000, rsvd0b_q};
            IDX_I_GAIN:      rdata_d = {16'h0000, i_gain_q};
            IDX_CMIX_Q_GAIN: rdata_d = {16'h0000, cmix_q};
            IDX_RSVD_0E:     rdata_d = {16'h0000, rsvd0e_q};
            IDX_OUT_LATENCY: rdata_d = {16'h0000, lat_q};
            IDX_PHASE:       rdata_d = {16'h0000, phase_q};
            IDX_SYNC_CFG:    rdata_d = {16'h0000, sync_q};
            default:         rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         aw_addr_q <= '0;
         w_data_q  <= '0;
         w_strb_q  <= '0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         rvalid_q  <= 1'b0;
         rresp_q   <= RESP_OKAY;
         rdata_q   <= '0;
         i_gain_q  <= RST_I_GAIN;
         cmix_q    <= RST_CMIX_Q_GAIN;
         lat_q     <= RST_OUT_LATENCY;
         phase_q   <= RST_PHASE;
         sync_q    <= RST_SYNC_CFG;
         rsvd0b_q  <= RST_RSVD_0B;
         rsvd0e_q  <= RST_RSVD_0E;
      end
      else
      begin
         aw_hold_q <= aw_hold_d;
         w_hold_q  <= w_hold_d;
         aw_addr_q <= aw_addr_d;
         w_data_q  <= w_data_d;
         w_strb_q  <= w_strb_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         rvalid_q  <= rvalid_d;
         rresp_q   <= rresp_d;
         rdata_q   <= rdata_d;
         i_gain_q  <= i_gain_d;
         cmix_q    <= cmix_d;
         lat_q     <= lat_d;
         phase_q   <= phase_d;
         sync_q    <= sync_d;
         rsvd0b_q  <= rsvd0b_d;
         rsvd0e_q  <= rsvd0e_d;
      end
   end

   assign s_axi_awready = !aw_hold_q;
   assign s_axi_wready  = !w_hold_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;

   // ************************************************************
   // Active correction values
   // ************************************************************
   // Gain writes only touch the shadow registers above; the datapath
   // reads these copies, loaded all at once by the sync event.
   logic [10:0] act_gi_q, act_gi_d, act_gq_q, act_gq_d;
   logic [11:0] act_ph_q, act_ph_d;
   logic [3:0]  act_mix_q, act_mix_d;

   always_comb
   begin
      act_gi_d  = act_gi_q;
      act_gq_d  = act_gq_q;
      act_ph_d  = act_ph_q;
      act_mix_d = act_mix_q;
      if (sync_evt)
      begin
         act_gi_d  = i_gain_q[GAIN_MSB:0];
         act_gq_d  = cmix_q[GAIN_MSB:0];
         act_mix_d = cmix_q[CMIX_MSB:CMIX_LSB];
         act_ph_d  = phase_d[PHASE_MSB:0];
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         act_gi_q  <= RST_I_GAIN[GAIN_MSB:0];
         act_gq_q  <= RST_CMIX_Q_GAIN[GAIN_MSB:0];
         act_ph_q  <= RST_PHASE[PHASE_MSB:0];
         act_mix_q <= RST_CMIX_Q_GAIN[CMIX_MSB:CMIX_LSB];
      end
      else
      begin
         act_gi_q  <= act_gi_d;
         act_gq_q  <= act_gq_d;
         act_ph_q  <= act_ph_d;
         act_mix_q <= act_mix_d;
      end
   end

   // ************************************************************
   // Sample path
   // ************************************************************
   iq_sample_t fifo_data;
   logic       fifo_valid;

   sample_fifo #(
      .WIDTH ($bits(iq_sample_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_data   (in_sample),
      .in_valid  (in_valid),
      .in_ready  (in_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (1'b1)
   );

   function automatic logic signed [15:0] sat(input logic signed [31:0] v);
      if (v > 32'sd32767)
         sat = 16'sh7fff;
      else if (v < -32'sd32768)
         sat = 16'sh8000;
      else
         sat = v[15:0];
   endfunction : sat

   function automatic logic signed [15:0] neg(input logic signed [15:0] v);
      neg = sat(-32'(v));
   endfunction : neg

   // Rotate by k eighths of a turn; odd eighths use 1/sqrt2 ~ 181/256.
   function automatic iq_sample_t rot(input iq_sample_t s,
                                      input logic [2:0] k);
      logic signed [31:0] a, b;
      iq_sample_t r;
      a = 32'($signed(s.i_smp));
      b = 32'($signed(s.q_smp));
      r = s;
      unique case (k)
         3'h0: r = s;
         3'h2: r = '{i_smp: neg(s.q_smp), q_smp: s.i_smp};
         3'h4: r = '{i_smp: neg(s.i_smp), q_smp: neg(s.q_smp)};
         3'h6: r = '{i_smp: s.q_smp, q_smp: neg(s.i_smp)};
         default:
         begin
            r.i_smp = sat(((a - b) * 32'sd181) >>> 8);
            r.q_smp = sat(((a + b) * 32'sd181) >>> 8);
            if (k[2])
               r = '{i_smp: neg(r.i_smp), q_smp: neg(r.q_smp)};
            if (k[1])
               r = '{i_smp: neg(r.q_smp), q_smp: r.i_smp};
         end
      endcase
      rot = r;
   endfunction : rot

   logic signed [31:0] i_corr, q_corr;
   iq_sample_t         corr, mixed;
   logic [2:0]         step_q, step_d, ang;
   logic               stg_v_q, stg_v_d;
   iq_sample_t         stg_q, stg_d;
   iq_sample_t         dly_q [4];
   logic               dly_v_q [4];
   logic [1:0]         lat;

   always_comb
   begin
      i_corr = (32'($signed(fifo_data.i_smp)) * 32'($signed({1'b0, act_gi_q})))
               >>> GAIN_FRAC;
      q_corr = (32'($signed(fifo_data.q_smp)) * 32'($signed({1'b0, act_gq_q})))
               >>> GAIN_FRAC;
      i_corr = i_corr + ((32'($signed(fifo_data.q_smp))
               * 32'($signed(act_ph_q))) >>> PHASE_FRAC);
      corr.i_smp = sat(i_corr);
      corr.q_smp = sat(q_corr);
      // Per-sample rotation step in eighths; zero leaves data unshifted.
      ang = 3'(act_mix_q[3]) + 3'({act_mix_q[2], 1'b0})
            + 3'({act_mix_q[1], 2'b00}) - 3'({act_mix_q[0], 1'b0});
      step_d  = fifo_valid ? step_q + ang : step_q;
      mixed   = rot(corr, step_q);
      stg_d   = fifo_valid ? mixed : stg_q;
      stg_v_d = fifo_valid;
      lat     = lat_q[LAT_MSB:LAT_LSB];
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         step_q  <= '0;
         stg_q   <= '0;
         stg_v_q <= 1'b0;
         for (int n = 0; n < 4; n++)
         begin
            dly_q[n]   <= '0;
            dly_v_q[n] <= 1'b0;
         end
         out_sample <= '0;
         out_valid  <= 1'b0;
      end
      else
      begin
         step_q     <= step_d;
         stg_q      <= stg_d;
         stg_v_q    <= stg_v_d;
         dly_q[0]   <= stg_q;
         dly_v_q[0] <= stg_v_q;
         for (int n = 1; n < 4; n++)
         begin
            dly_q[n]   <= dly_q[n-1];
            dly_v_q[n] <= dly_v_q[n-1];
         end
         out_sample <= (lat == 2'h0) ? stg_q : dly_q[lat - 2'h1];
         out_valid  <= (lat == 2'h0) ? stg_v_q : dly_v_q[lat - 2'h1];
      end
   end

endmodule : iq_gain_phase_coarse_mixer

//--- iq_corr_props.sv
`timescale 1ns/1ps
// ****
// Port checks for the correction stage.
// ****
module iq_corr_props
   import iq_corr_pkg::*;
(
   // Clock and reset
   input wire logic                    sys_clk,
   input wire logic                    rst,
   // Register bus
   input wire logic                    s_axi_awvalid,
   input wire logic                    s_axi_awready,
   input wire logic                    s_axi_wvalid,
   input wire logic                    s_axi_wready,
   input wire logic                    s_axi_bvalid,
   input wire logic                    s_axi_bready,
   input wire logic                    s_axi_arvalid,
   input wire logic                    s_axi_arready,
   input wire logic                    s_axi_rvalid,
   input wire logic [1:0]              s_axi_rresp,
   input wire logic [31:0]             s_axi_rdata,
   // Samples
   input wire logic                    in_valid,
   input wire logic                    in_ready,
   input wire logic                    out_valid,
   input wire iq_corr_pkg::iq_sample_t out_sample
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // Samples taken but not yet emitted; an output with none owed is bogus.
   logic [4:0] pend_q, pend_d;
   always_comb
      pend_d = pend_q + 5'(in_valid && in_ready) - 5'(out_valid);
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         pend_q <= 5'h00;
      else
         pend_q <= pend_d;

   sequence take_s;
      in_valid && in_ready;
   endsequence
   sequence aw_w_s;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence

   rst_state_a: assert property ($fell(rst) |-> s_axi_awready && s_axi_wready
      && s_axi_arready && in_ready && !s_axi_bvalid && !s_axi_rvalid
      && !out_valid && out_sample == '0) else $error("bad state after reset");
   ar_gate_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   wr_answer_a: assert property (aw_w_s |-> ##[1:3] s_axi_bvalid)
      else $error("write response missing");
   resp_once_a: assert property (s_axi_bvalid && s_axi_bready
      |=> !s_axi_bvalid) else $error("write response repeated");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read data late");
   rd_err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
      |-> s_axi_rdata == 32'h0) else $error("error read returned data");
   rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
      else $error("upper read half not zero");
   out_latency_a: assert property (take_s |-> ##[3:8] out_valid)
      else $error("sample output late");
   out_cause_a: assert property (out_valid |-> pend_q != 5'h00)
      else $error("output without input");
endmodule : iq_corr_props

bind iq_gain_phase_coarse_mixer iq_corr_props iq_corr_props_inst (
   .sys_clk(sys_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata),
   .in_valid(in_valid), .in_ready(in_ready), .out_valid(out_valid),
   .out_sample(out_sample));

//--- sample_source.sv
`timescale 1ns/1ps
// ****
// Upstream sample source.
// ****
module sample_source
   import iq_corr_pkg::*;
(
   // Clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    rst,
   // Requests from the bench
   input  wire logic                    send,
   input  wire iq_corr_pkg::iq_sample_t send_data,
   // Sample stream
   output iq_corr_pkg::iq_sample_t      smp,
   output logic                         smp_valid,
   input  wire logic                    smp_ready
);
   iq_sample_t smp_q, smp_d;
   logic       vld_q, vld_d;

   // A released word is inverted so a stale sample never looks valid.
   always_comb
   begin
      smp_d = smp_q;
      vld_d = vld_q;
      if (vld_q && smp_ready)
      begin
         vld_d = 1'b0;
         smp_d = ~smp_q;
      end
      else if (send && !vld_q)
      begin
         vld_d = 1'b1;
         smp_d = send_data;
      end
   end
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
      begin
         smp_q <= '0;
         vld_q <= 1'b0;
      end
      else
      begin
         smp_q <= smp_d;
         vld_q <= vld_d;
      end
   assign smp = smp_q;
   assign smp_valid = vld_q;
endmodule : sample_source

//--- tb_top.sv
`timescale 1ns/1ps
// ****
// Bench for the correction stage.
// ****
module tb_top;
   import iq_corr_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic [9:0]  awaddr = 10'h000;
   logic [9:0]  araddr = 10'h000;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, src_send = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        in_valid, in_ready, out_valid;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   iq_sample_t  in_s, out_s, outq[$];
   iq_sample_t  src_data = '0;
   int          takeq[$], latq[$];
   int          n_mismatch = 0, total_checks = 0, cyc = 0, base = 0;

   always #20 sys_clk = ~sys_clk;

   iq_gain_phase_coarse_mixer #(.FIFO_DEPTH(8))
      iq_gain_phase_coarse_mixer_inst (
      .sys_clk(sys_clk), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .in_sample(in_s),
      .in_valid(in_valid), .in_ready(in_ready), .out_sample(out_s),
      .out_valid(out_valid));
   sample_source sample_source_inst (
      .sys_clk(sys_clk), .rst(rst), .send(src_send), .send_data(src_data),
      .smp(in_s), .smp_valid(in_valid), .smp_ready(in_ready));

   always @(posedge sys_clk)
   begin
      cyc++;
      if (in_valid && in_ready)
         takeq.push_back(cyc);
      if (out_valid)
      begin
         outq.push_back(out_s);
         latq.push_back(cyc - takeq.pop_front());
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] idx, input logic [15:0] v);
      @(posedge sys_clk);
      awaddr  <= {idx, 2'b00};
      wdata   <= {16'h0000, v};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
      end
      while (!bvalid);
      bready <= 1'b0;
      chk({29'h0, bvalid, bresp}, {29'h0, 1'b1, RESP_OKAY});
   endtask : wr

   task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge sys_clk);
      araddr  <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (arvalid && arready)
            arvalid <= 1'b0;
      end
      while (!rvalid);
      rready <= 1'b0;
      d = rdata;
      r = rresp;
      chk({16'h0000, rdata[31:16]}, 32'h0);
   endtask : rd

   // Sends one sample and waits for its output word and latency.
   task automatic xfer(input iq_sample_t s, output iq_sample_t o,
                       output int l);
      int n;
      @(posedge sys_clk);
      src_data <= s;
      src_send <= 1'b1;
      @(posedge sys_clk);
      src_send <= 1'b0;
      n = 0;
      while (outq.size() == 0 && n < 40)
      begin
         @(posedge sys_clk);
         n++;
      end
      o = '1;
      l = -1;
      if (outq.size() > 0)
      begin
         o = outq.pop_front();
         l = latq.pop_front();
      end
   endtask : xfer

   task automatic t_regs;
      logic [7:0]  idx [6] = '{IDX_RSVD_0B, IDX_I_GAIN, IDX_CMIX_Q_GAIN,
                               IDX_RSVD_0E, IDX_OUT_LATENCY, IDX_PHASE};
      logic [15:0] rv [6] = '{RST_RSVD_0B, RST_I_GAIN, RST_CMIX_Q_GAIN,
                              RST_RSVD_0E, RST_OUT_LATENCY, RST_PHASE};
      logic [31:0] d;
      logic [1:0]  r;
      for (int k = 0; k < 6; k++)
      begin
         rd(idx[k], d, r);
         chk(d, {16'h0000, rv[k]});
      end
      rd(8'h20, d, r);
      chk(d, 32'h0);
      chk(32'(r), 32'(RESP_SLVERR));
   endtask : t_regs

   task automatic t_pass;
      iq_sample_t o;
      xfer({16'h1234, 16'hedcb}, o, base);
      chk(o, {16'h1234, 16'hedcb});
   endtask : t_pass

   task automatic t_gain;
      iq_sample_t o;
      int         l;
      wr(IDX_SYNC_CFG, 16'h0001);
      wr(IDX_I_GAIN, 16'h0200);
      wr(IDX_CMIX_Q_GAIN, 16'h0600);
      xfer({16'hf800, 16'h0800}, o, l);
      chk(o, {16'hf800, 16'h0800});
      wr(IDX_PHASE, 16'h3000);
      xfer({16'hf800, 16'h0800}, o, l);
      chk(o, {16'hfc00, 16'h0c00});
   endtask : t_gain

   task automatic t_phase;
      iq_sample_t  o;
      int          l;
      logic [31:0] d;
      logic [1:0]  r;
      wr(IDX_I_GAIN, 16'h0400);
      wr(IDX_CMIX_Q_GAIN, 16'h0400);
      wr(IDX_PHASE, 16'h3800);
      xfer({16'h0100, 16'h0800}, o, l);
      chk(o, {16'hfd00, 16'h0800});
      wr(IDX_PHASE, 16'h3400);
      xfer({16'h0100, 16'h0800}, o, l);
      chk(o, {16'h0300, 16'h0800});
      wr(IDX_SYNC_CFG, 16'h0000);
      wr(IDX_PHASE, 16'h3000);
      xfer({16'h0100, 16'h0800}, o, l);
      chk(o, {16'h0300, 16'h0800});
      rd(IDX_PHASE, d, r);
      chk(d, 32'h3000);
      wr(IDX_SYNC_CFG, 16'h0001);
      wr(IDX_PHASE, 16'h3000);
      xfer({16'h0100, 16'h0800}, o, l);
      chk(o, {16'h0100, 16'h0800});
   endtask : t_phase

   task automatic t_mix;
      logic [3:0] sel [6] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1, 4'hc};
      iq_sample_t o, o2;
      int         l, same, flip;
      for (int k = 0; k < 6; k++)
      begin
         wr(IDX_CMIX_Q_GAIN, {sel[k], 12'h400});
         wr(IDX_PHASE, 16'h3000);
         same = 0;
         flip = 0;
         for (int j = 0; j < 8; j++)
         begin
            xfer({16'h1000, 16'h0000}, o, l);
            if (j == 1)
               o2 = o;
            same += int'(o === {16'h1000, 16'h0000});
            flip += int'(o === {16'h1000, 16'h0000}
                         || o === {16'hf000, 16'h0});
         end
         chk(32'(same == 8), 32'(sel[k] == 4'h0));
         if (sel[k] == 4'h4)
            chk(o2, {16'h0000, 16'h1000});
         if (sel[k] == 4'h1)
            chk(o2, {16'h0000, 16'hf000});
         if (sel[k] == 4'h2)
            chk(32'(flip), 32'd8);
      end
      wr(IDX_CMIX_Q_GAIN, 16'h0400);
      wr(IDX_PHASE, 16'h3000);
   endtask : t_mix

   task automatic t_lat;
      iq_sample_t o;
      int         l;
      for (int k = 1; k < 4; k++)
      begin
         wr(IDX_OUT_LATENCY, {2'(k), 14'h0400});
         xfer({16'h0042, 16'h0024}, o, l);
         chk(32'(l), 32'(base + k));
      end
      wr(IDX_OUT_LATENCY, 16'h0400);
   endtask : t_lat

   task automatic complete_run;
      if (n_mismatch == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run

   initial
   begin
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      t_regs;
      t_pass;
      t_gain;
      t_phase;
      t_mix;
      t_lat;
      complete_run;
   end

   // The full sequence needs well under a tenth of this span.
   initial
   begin
      repeat (30000) @(posedge sys_clk);
      n_mismatch++;
      complete_run;
   end
endmodule : tb_top
